// ===== lsfd_pkg.sv
// Constants shared by the segment LCD frame driver
package lsfd_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_DIVIDER  = 8'h04;
   localparam logic [7:0] OFS_STATUS   = 8'h08;
   localparam logic [7:0] OFS_SEGEN_LO = 8'h0c;
   localparam logic [7:0] OFS_SEGEN_HI = 8'h10;
   localparam logic [7:0] OFS_PIXEL    = 8'h20;
   localparam logic [7:0] PIXEL_STRIDE = 8'h08;
   localparam logic [7:0] PIXEL_HI_OFS = 8'h04;
   // Control field positions
   localparam int CTRL_EN      = 0;
   localparam int CTRL_HALT    = 1;
   localparam int CTRL_SRC     = 2;
   localparam int CTRL_MUX     = 4;
   localparam int CTRL_TYPEB   = 6;
   // Status field positions
   localparam int ST_FRAME     = 0;
   localparam int ST_LATE      = 1;
   localparam int ST_WINDOW    = 2;
   localparam int ST_HALTED    = 3;
   localparam int ST_BP        = 4;
   // Reset values
   localparam logic [6:0] CTRL_RST  = 7'h00;
   localparam logic [3:0] DIV_RST   = 4'h0;
   // Backplane count select codes
   localparam logic [1:0] MUX_STATIC = 2'h0;
   localparam logic [1:0] MUX_HALF   = 2'h1;
   localparam logic [1:0] MUX_THIRD  = 2'h2;
   localparam logic [1:0] MUX_QUART  = 2'h3;
   // Timing source codes
   localparam logic [1:0] SRC_SYS    = 2'h0;
   localparam logic [1:0] SRC_SLOW   = 2'h1;
   // Steps per frame, last step index
   localparam logic [1:0] LAST_STEP_3 = 2'h2;
   localparam logic [1:0] LAST_STEP_4 = 2'h3;
   // Drive level codes, V0 is the minimum LCD level
   localparam logic [1:0] LVL_V0 = 2'h0;
   localparam logic [1:0] LVL_V1 = 2'h1;
   localparam logic [1:0] LVL_V2 = 2'h2;
   localparam logic [1:0] LVL_V3 = 2'h3;
endpackage

// ===== lsfd_driver.sv
// Segment LCD frame timing core with Avalon-MM register slave
`timescale 1ns/1ns
module lsfd_driver
   import lsfd_pkg::*;
#(
   parameter int NSEG    = 33,
   parameter int SYS_DIV = 8192
) (
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 rstn,
   // Avalon-MM slave
   input  wire logic [7:0]           address,
   input  wire logic                 read,
   input  wire logic                 write,
   input  wire logic [31:0]          writedata,
   output logic      [31:0]          readdata,
   output logic                      waitrequest,
   // Core power state and oscillator pins
   input  wire logic                 core_sleep,
   input  wire logic                 osc_slow_pin,
   input  wire logic                 osc_fast_pin,
   // Panel drive
   output logic      [3:0][1:0]      bp_level,
   output logic      [NSEG-1:0][1:0] seg_level,
   output logic      [NSEG-1:0]      pixel_column_drive,
   output logic      [2:0]           shared_pin_group,
   output logic                      frame_flag
);
   // Register state
   logic [6:0]            ctrl_r, ctrl_nxt;
   logic [3:0]            frame_divider_r, frame_divider_nxt;
   logic [NSEG-1:0]       segment_pin_enable_r, segment_pin_enable_nxt;
   logic [3:0][NSEG-1:0]  pixel_state_bits_r, pixel_state_bits_nxt;
   logic                  frame_flag_r, frame_flag_nxt;
   logic                  late_write_flag_r, late_write_flag_nxt;
   logic                  ack_r, ack_nxt;
   logic [31:0]           rd_r, rd_nxt;
   // Timing state
   logic [2:0]            slow_sync_r, slow_sync_nxt;
   logic [2:0]            fast_sync_r, fast_sync_nxt;
   logic [15:0]           sys_cnt_r, sys_cnt_nxt;
   logic [3:0]            presc_r, presc_nxt;
   logic [1:0]            step_r, step_nxt;
   logic                  parity_r, parity_nxt;
   logic                  window_r, window_nxt;
   logic [NSEG-1:0]       col_r, col_nxt;
   logic [3:0][1:0]       bp_lvl_nxt;
   logic [NSEG-1:0][1:0]  seg_lvl_nxt;
   // Decoded control
   logic       enable, halt_sel, typeb, halted, run, src_tick, step_tick, phase;
   logic [1:0] mux, src, last_step, cur_bp, new_bp;
   logic       bus_ack, wr_ack, pix_sel, pix_write, pix_block, frame_irq;
   logic [2:0] pix_bp;

   function automatic logic [1:0] bp_of(input logic [1:0] m, input logic [1:0] s);
      logic [1:0] b;
      b = s;
      if (m == MUX_STATIC) begin
         b = 2'h0;
      end else if (m == MUX_HALF) begin
         b = {1'b0, s[1]};
      end
      return b;
   endfunction

   assign enable    = ctrl_r[CTRL_EN];
   assign halt_sel  = ctrl_r[CTRL_HALT];
   assign src       = ctrl_r[CTRL_SRC +: 2];
   assign mux       = ctrl_r[CTRL_MUX +: 2];
   assign typeb     = ctrl_r[CTRL_TYPEB];
   assign halted    = core_sleep & (halt_sel | (src == SRC_SYS));
   assign run       = enable & ~halted;
   assign last_step = (mux == MUX_THIRD) ? LAST_STEP_3 : LAST_STEP_4;
   assign cur_bp    = bp_of(mux, step_r);

   // Bus handshake: one wait cycle, then the answer
   assign waitrequest = (read | write) & ~ack_r;
   assign bus_ack     = (read | write) & ack_r;
   assign wr_ack      = write & ack_r;
   assign readdata    = rd_r;

   // Timing source select and divide
   always_comb begin
      slow_sync_nxt = {slow_sync_r[1:0], osc_slow_pin};
      fast_sync_nxt = {fast_sync_r[1:0], osc_fast_pin};
      sys_cnt_nxt   = sys_cnt_r;
      src_tick      = 1'b0;
      if (src == SRC_SYS) begin
         if (sys_cnt_r == 16'(SYS_DIV - 1)) begin
            sys_cnt_nxt = 16'h0000;
            src_tick    = 1'b1;
         end else begin
            sys_cnt_nxt = sys_cnt_r + 16'h0001;
         end
      end else if (src == SRC_SLOW) begin
         src_tick = slow_sync_r[1] & ~slow_sync_r[2];
      end else begin
         src_tick = fast_sync_r[1] & ~fast_sync_r[2];
      end
      if (!run) begin
         src_tick = 1'b0;
      end
   end

   // Frame sequencer and pixel fetch
   always_comb begin
      presc_nxt  = presc_r;
      step_nxt   = step_r;
      parity_nxt = parity_r;
      window_nxt = window_r;
      col_nxt    = col_r;
      step_tick  = 1'b0;
      frame_irq  = 1'b0;
      new_bp     = cur_bp;
      if (!enable) begin
         presc_nxt  = 4'h0;
         step_nxt   = 2'h0;
         parity_nxt = 1'b0;
         window_nxt = 1'b0;
         col_nxt    = pixel_state_bits_r[0];
      end else if (src_tick) begin
         if (presc_r == frame_divider_r) begin
            presc_nxt = 4'h0;
            step_tick = 1'b1;
         end else begin
            presc_nxt = presc_r + 4'h1;
         end
      end
      if (step_tick) begin
         window_nxt = 1'b0;
         if (step_r == last_step) begin
            step_nxt   = 2'h0;
            parity_nxt = ~parity_r;
         end else begin
            step_nxt = step_r + 2'h1;
         end
         new_bp  = bp_of(mux, step_nxt);
         col_nxt = pixel_state_bits_r[new_bp];
         if (typeb && mux != MUX_STATIC && step_nxt == last_step && parity_r) begin
            frame_irq  = 1'b1;
            window_nxt = 1'b1;
         end
      end
   end

   // Waveform levels per line
   always_comb begin
      phase = parity_r;
      if (!typeb) begin
         if (mux == MUX_STATIC) begin
            phase = step_r[1];
         end else if (mux == MUX_HALF) begin
            phase = step_r[0];
         end else begin
            phase = presc_r > (frame_divider_r >> 1);
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_bp
         always_comb begin
            bp_lvl_nxt[gi] = LVL_V0;
            if (run && gi <= int'(mux)) begin
               if (2'(gi) == cur_bp) begin
                  bp_lvl_nxt[gi] = phase ? LVL_V3 : LVL_V0;
               end else begin
                  bp_lvl_nxt[gi] = phase ? LVL_V1 : LVL_V2;
               end
            end
         end
      end
      for (gi = 0; gi < NSEG; gi++) begin : g_seg
         always_comb begin
            seg_lvl_nxt[gi] = LVL_V0;
            if (run && segment_pin_enable_r[gi]) begin
               if (col_r[gi]) begin
                  seg_lvl_nxt[gi] = phase ? LVL_V0 : LVL_V3;
               end else if (mux == MUX_STATIC) begin
                  seg_lvl_nxt[gi] = phase ? LVL_V3 : LVL_V0;
               end else begin
                  seg_lvl_nxt[gi] = phase ? LVL_V2 : LVL_V1;
               end
            end
         end
      end
   endgenerate

   // Register writes, flags and read data
   always_comb begin
      ctrl_nxt               = ctrl_r;
      frame_divider_nxt      = frame_divider_r;
      segment_pin_enable_nxt = segment_pin_enable_r;
      pixel_state_bits_nxt   = pixel_state_bits_r;
      frame_flag_nxt         = frame_flag_r;
      late_write_flag_nxt    = late_write_flag_r;
      ack_nxt                = (read | write) & ~ack_r;
      rd_nxt                 = 32'h0000_0000;
      pix_sel   = (address >= OFS_PIXEL) && (address < OFS_PIXEL + 4 * PIXEL_STRIDE)
                  && (address[1:0] == 2'h0);
      pix_bp    = 3'((address - OFS_PIXEL) >> 3);
      pix_write = wr_ack & pix_sel;
      pix_block = core_sleep
                  | (typeb && mux != MUX_STATIC && !window_r);
      if (wr_ack) begin
         case (address)
            OFS_CTRL: begin
               ctrl_nxt = writedata[6:0];
            end
            OFS_DIVIDER: begin
               frame_divider_nxt = writedata[3:0];
            end
            OFS_STATUS: begin
               if (writedata[ST_FRAME]) begin
                  frame_flag_nxt = 1'b0;
               end
               if (writedata[ST_LATE]) begin
                  late_write_flag_nxt = 1'b0;
               end
            end
            OFS_SEGEN_LO: begin
               segment_pin_enable_nxt[31:0] = writedata;
            end
            OFS_SEGEN_HI: begin
               segment_pin_enable_nxt[NSEG-1:32] = writedata[NSEG-33:0];
            end
            default: begin
            end
         endcase
      end
      if (pix_write) begin
         if (pix_block) begin
            late_write_flag_nxt = 1'b1;
         end else if ((address & PIXEL_HI_OFS) != 8'h00) begin
            pixel_state_bits_nxt[pix_bp[1:0]][NSEG-1:32] = writedata[NSEG-33:0];
         end else begin
            pixel_state_bits_nxt[pix_bp[1:0]][31:0] = writedata;
         end
      end
      if (frame_irq) begin
         frame_flag_nxt = 1'b1;
      end
      if (ack_nxt && read) begin
         case (address)
            OFS_CTRL:     rd_nxt[6:0] = ctrl_r;
            OFS_DIVIDER:  rd_nxt[3:0] = frame_divider_r;
            OFS_STATUS: begin
               rd_nxt[ST_FRAME]    = frame_flag_r;
               rd_nxt[ST_LATE]     = late_write_flag_r;
               rd_nxt[ST_WINDOW]   = window_r;
               rd_nxt[ST_HALTED]   = halted;
               rd_nxt[ST_BP +: 2]  = cur_bp;
            end
            OFS_SEGEN_LO: rd_nxt = segment_pin_enable_r[31:0];
            OFS_SEGEN_HI: rd_nxt[NSEG-33:0] = segment_pin_enable_r[NSEG-1:32];
            default: begin
               if (pix_sel && (address & PIXEL_HI_OFS) != 8'h00) begin
                  rd_nxt[NSEG-33:0] = pixel_state_bits_r[pix_bp[1:0]][NSEG-1:32];
               end else if (pix_sel) begin
                  rd_nxt = pixel_state_bits_r[pix_bp[1:0]][31:0];
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         ctrl_r               <= CTRL_RST;
         frame_divider_r      <= DIV_RST;
         segment_pin_enable_r <= '0;
         pixel_state_bits_r   <= '0;
         frame_flag_r         <= 1'b0;
         late_write_flag_r    <= 1'b0;
         ack_r                <= 1'b0;
         rd_r                 <= 32'h0000_0000;
         slow_sync_r          <= 3'h0;
         fast_sync_r          <= 3'h0;
         sys_cnt_r            <= 16'h0000;
         presc_r              <= 4'h0;
         step_r               <= 2'h0;
         parity_r             <= 1'b0;
         window_r             <= 1'b0;
         col_r                <= '0;
         bp_level             <= '0;
         seg_level            <= '0;
         pixel_column_drive   <= '0;
         shared_pin_group     <= 3'h0;
         frame_flag           <= 1'b0;
      end else begin
         ctrl_r               <= ctrl_nxt;
         frame_divider_r      <= frame_divider_nxt;
         segment_pin_enable_r <= segment_pin_enable_nxt;
         pixel_state_bits_r   <= pixel_state_bits_nxt;
         frame_flag_r         <= frame_flag_nxt;
         late_write_flag_r    <= late_write_flag_nxt;
         ack_r                <= ack_nxt;
         rd_r                 <= rd_nxt;
         slow_sync_r          <= slow_sync_nxt;
         fast_sync_r          <= fast_sync_nxt;
         sys_cnt_r            <= sys_cnt_nxt;
         presc_r              <= presc_nxt;
         step_r               <= step_nxt;
         parity_r             <= parity_nxt;
         window_r             <= window_nxt;
         col_r                <= col_nxt;
         bp_level             <= bp_lvl_nxt;
         seg_level            <= seg_lvl_nxt;
         pixel_column_drive   <= segment_pin_enable_nxt;
         shared_pin_group     <= {mux == MUX_QUART, mux >= MUX_THIRD, mux != MUX_STATIC};
         frame_flag           <= frame_flag_nxt;
      end
   end
endmodule

// ===== lsfd_driver_monitor.sv
// Assertion checker for the segment LCD frame driver
`timescale 1ns/1ns
module lsfd_driver_monitor
   import lsfd_pkg::*;
#(
   parameter int NSEG = 33
) (
   // Clock, reset and bus
   input wire logic                 clock,
   input wire logic                 rstn,
   input wire logic [7:0]           address,
   input wire logic                 read,
   input wire logic                 write,
   input wire logic [31:0]          writedata,
   input wire logic [31:0]          readdata,
   input wire logic                 waitrequest,
   // Power state and panel
   input wire logic                 core_sleep,
   input wire logic [3:0][1:0]      bp_level,
   input wire logic [NSEG-1:0][1:0] seg_level,
   input wire logic [NSEG-1:0]      pixel_column_drive,
   input wire logic [2:0]           shared_pin_group,
   input wire logic                 frame_flag
);
   logic [6:0] ctrl_r;
   logic [6:0] ctrl_nxt;
   logic       acc_w;
   logic       hlt;
   logic [2:0] pin_exp;
   assign acc_w = write && !waitrequest;
   assign hlt = !ctrl_r[CTRL_EN] ||
                (core_sleep && (ctrl_r[CTRL_HALT] || ctrl_r[3:2] == SRC_SYS));
   assign pin_exp = {ctrl_r[5:4] == MUX_QUART, ctrl_r[5:4] >= MUX_THIRD,
                     ctrl_r[5:4] != MUX_STATIC};
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (acc_w && address == OFS_CTRL) begin
         ctrl_nxt = writedata[6:0];
      end
   end
   always_ff @(posedge clock) begin
      if (!rstn) begin
         ctrl_r <= CTRL_RST;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   sequence s_waiting;
      (read || write) && waitrequest;
   endsequence
   sequence s_taken;
      (read || write) && !waitrequest;
   endsequence
   a_wait_first: assert property (s_waiting |=> !waitrequest)
      else $error("request not answered after one cycle");
   a_wait_once: assert property (s_taken |=> !(read || write) || waitrequest)
      else $error("second request answered without wait");
   a_rdata_zero: assert property (!(read && !waitrequest) |-> readdata == '0)
      else $error("read data outside answer cycle");
   a_reset_clear: assert property (
      $rose(rstn) |-> shared_pin_group == '0 && pixel_column_drive == '0 && !frame_flag)
      else $error("outputs not cleared by reset");
   a_pins_mux: assert property (
      ctrl_r[5:4] == $past(ctrl_r[5:4]) && ctrl_r[5:4] == $past(ctrl_r[5:4], 2)
      |-> shared_pin_group == pin_exp) else $error("shared pins wrong for count");
   a_seg_idle: assert property (
      pixel_column_drive == '0 && $past(pixel_column_drive) == '0 |-> seg_level == '0)
      else $error("disabled segment driven");
   a_flag_sticky: assert property (
      frame_flag && !(acc_w && address == OFS_STATUS && writedata[ST_FRAME])
      |=> frame_flag) else $error("frame flag dropped");
   a_flag_mode: assert property (
      $rose(frame_flag) |-> $past(ctrl_r[CTRL_TYPEB]) && $past(ctrl_r[5:4]) != MUX_STATIC)
      else $error("frame flag in wrong mode");
   a_halt_min: assert property (
      hlt && $past(hlt) |-> bp_level == '0 && seg_level == '0)
      else $error("lines not at minimum while halted");
endmodule
bind lsfd_driver lsfd_driver_monitor #(.NSEG(NSEG)) i_mon (
   .clock(clock), .rstn(rstn), .address(address), .read(read),
   .write(write), .writedata(writedata), .readdata(readdata),
   .waitrequest(waitrequest), .core_sleep(core_sleep), .bp_level(bp_level),
   .seg_level(seg_level), .pixel_column_drive(pixel_column_drive),
   .shared_pin_group(shared_pin_group), .frame_flag(frame_flag)
);

// ===== lsfd_glass.sv
// Panel model summing the net voltage across one pixel
`timescale 1ns/1ns
module lsfd_glass (
   // Clock
   input  wire logic       clock,
   // Electrode levels of backplane 0 and segment 0
   input  wire logic [1:0] bp0,
   input  wire logic [1:0] seg0,
   // Running charge on the pixel
   output int              dc_sum
);
   initial dc_sum = 0;
   always @(posedge clock) begin
      dc_sum <= dc_sum + int'(bp0) - int'(seg0);
   end
endmodule

// ===== lsfd_driver_bench.sv
// Self-checking bench for the segment LCD frame driver
`timescale 1ns/1ns
module lsfd_driver_bench
   import lsfd_pkg::*;
;
   localparam int SD = 4;
   logic             clock;
   logic             rstn;
   logic [7:0]       address;
   logic             read;
   logic             write;
   logic [31:0]      writedata;
   logic [31:0]      readdata;
   logic             waitrequest;
   logic             core_sleep;
   logic             osc_slow_pin;
   logic             osc_fast_pin;
   logic [3:0][1:0]  bp_level;
   logic [32:0][1:0] seg_level;
   logic [32:0]      pixel_column_drive;
   logic [2:0]       shared_pin_group;
   logic             frame_flag;
   logic             slow_run;
   logic [31:0]      rd;
   logic [32:0]      pin_direction;
   logic [3:0][1:0]  pb;
   int               dc_sum;
   int               fails;
   int               num_checks;
   int               cyc;
   int               t0, t1, d0, m, dv, ch;
   lsfd_driver #(.NSEG(33), .SYS_DIV(SD)) i_dut (
      .clock(clock), .rstn(rstn), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .core_sleep(core_sleep), .osc_slow_pin(osc_slow_pin), .osc_fast_pin(osc_fast_pin),
      .bp_level(bp_level), .seg_level(seg_level), .frame_flag(frame_flag),
      .pixel_column_drive(pixel_column_drive), .shared_pin_group(shared_pin_group)
   );
   lsfd_glass i_glass (.clock(clock), .bp0(bp_level[0]), .seg0(seg_level[0]),
      .dc_sum(dc_sum));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (slow_run && cyc % 3 == 0) osc_slow_pin <= !osc_slow_pin;
      if (cyc % 2 == 0) osc_fast_pin <= !osc_fast_pin;
   end
   task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= d;
      do begin
         @(posedge clock);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (n >= 50) fails++;
      @(posedge clock);
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, 33'(e), 33'(rd));
   endtask
   task automatic cfg(input int mx, input int tb, input logic [1:0] src, input int h);
      bus(1'b1, OFS_CTRL, 32'(1 << CTRL_EN | tb << CTRL_TYPEB | mx << CTRL_MUX
          | src << CTRL_SRC | h << CTRL_HALT));
   endtask
   task automatic wait_flag(output int t);
      int n;
      n = 0;
      while (frame_flag !== 1'b1 && n < 3000) begin
         @(posedge clock);
         n++;
      end
      t = cyc;
      if (n >= 3000) fails++;
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      wrap_up();
   end
   initial begin
      {rstn, read, write, core_sleep, osc_slow_pin, osc_fast_pin, slow_run} = '0;
      pin_direction = 33'h0;
      address = 8'h00;
      writedata = 32'h0;
      {cyc, fails, num_checks} = '0;
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      chk("pins", 33'h0, 33'(shared_pin_group));
      chk("seg_drive", 33'h0, pixel_column_drive);
      rdchk("ctrl", OFS_CTRL, 32'h0);
      rdchk("divider", OFS_DIVIDER, 32'h0);
      rdchk("segen_lo", OFS_SEGEN_LO, 32'h0);
      bus(1'b1, 8'h1c, 32'hffffffff);
      rdchk("unmapped", 8'h1c, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, OFS_CTRL, 32'(i << CTRL_MUX));
         repeat (2) @(posedge clock);
         chk("pin_group", 33'((1 << i) - 1), 33'(shared_pin_group));
      end
      bus(1'b1, OFS_SEGEN_LO, 32'ha5a5a5a5);
      bus(1'b1, OFS_SEGEN_HI, 32'h1);
      chk("seg_drive", 33'h1a5a5a5a5, pixel_column_drive);
      pin_direction = 33'h1a5a5a5a5;
      chk("seg_dir", 33'h0, pixel_column_drive & ~pin_direction);
      rdchk("segen_lo", OFS_SEGEN_LO, 32'ha5a5a5a5);
      $display("test pins done");
      for (int b = 0; b < 4; b++) begin
         bus(1'b1, 8'(OFS_PIXEL + b * 8), 32'h5a0c3e01 + 32'(b) * 32'h01010100);
         bus(1'b1, 8'(OFS_PIXEL + b * 8 + 4), 32'(b & 1));
      end
      for (int b = 0; b < 4; b++) begin
         rdchk("pix_lo", 8'(OFS_PIXEL + b * 8), 32'h5a0c3e01 + 32'(b) * 32'h01010100);
         rdchk("pix_hi", 8'(OFS_PIXEL + b * 8 + 4), 32'(b & 1));
      end
      $display("test pixels done");
      for (int i = 0; i < 3; i++) begin
         m = i + 1;
         dv = i / 2 + 1;
         bus(1'b1, OFS_DIVIDER, 32'(dv));
         cfg(m, 1, (i == 2) ? 2'h2 : SRC_SYS, 0);
         wait_flag(t0);
         bus(1'b1, OFS_STATUS, 32'h1);
         wait_flag(t0);
         d0 = dc_sum;
         bus(1'b0, OFS_STATUS, 32'h0);
         chk("window", 33'h5, 33'(rd[2:0]));
         bus(1'b1, OFS_STATUS, 32'h1);
         wait_flag(t1);
         chk("pair_dc", 33'h0, 33'(dc_sum - d0));
         chk("pair_len", 33'(2 * (m == 2 ? 3 : 4) * (dv + 1) * SD), 33'(t1 - t0));
         bus(1'b1, OFS_STATUS, 32'h1);
      end
      $display("test frame rate done");
      wait_flag(t0);
      bus(1'b1, OFS_PIXEL + 8'h08, 32'h7777);
      repeat (24) @(posedge clock);
      bus(1'b1, OFS_PIXEL + 8'h08, 32'h12340000);
      rdchk("pix_kept", OFS_PIXEL + 8'h08, 32'h7777);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("late", 33'h1, 33'(rd[ST_LATE]));
      repeat (100) @(posedge clock);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("late_held", 33'h1, 33'(rd[ST_LATE]));
      bus(1'b1, OFS_STATUS, 32'h3);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("late_clr", 33'h0, 33'(rd[ST_LATE]));
      $display("test late write done");
      for (int i = 0; i < 2; i++) begin
         cfg(3 * (1 - i), i, SRC_SYS, 0);
         bus(1'b1, OFS_STATUS, 32'h3);
         repeat (300) @(posedge clock);
         chk("no_flag", 33'h0, 33'(frame_flag));
      end
      $display("test no interrupt done");
      cfg(3, 1, SRC_SLOW, 1);
      slow_run <= 1'b1;
      wait_flag(t0);
      core_sleep <= 1'b1;
      repeat (4) @(posedge clock);
      chk("halt_bp", 33'h0, 33'(bp_level));
      chk("halt_seg", 33'h0, 33'(|seg_level));
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("halted", 33'h1, 33'(rd[ST_HALTED]));
      cfg(3, 1, SRC_SLOW, 0);
      ch = 0;
      pb = bp_level;
      repeat (300) begin
         @(posedge clock);
         if (bp_level !== pb) ch++;
         pb = bp_level;
      end
      chk("runs", 33'h1, 33'(ch > 0));
      bus(1'b1, OFS_PIXEL, 32'h0);
      rdchk("pix_frozen", OFS_PIXEL, 32'h5a0c3e01);
      cfg(3, 1, SRC_SYS, 0);
      repeat (4) @(posedge clock);
      chk("sys_halt", 33'h0, 33'(bp_level));
      core_sleep <= 1'b0;
      repeat (40) @(posedge clock);
      chk("wake", 33'h1, 33'(|bp_level));
      $display("test sleep done");
      wrap_up();
   end
endmodule
